// file: gac_pkg.sv
// Package of constants for the gauge alert output configuration block
package gac_pkg;
    // Register byte addresses (word aligned)
    localparam logic [7:0] ADDR_OPCFG     = 8'h00;
    localparam logic [7:0] ADDR_THRESH_A  = 8'h04;
    localparam logic [7:0] ADDR_THRESH_B  = 8'h08;
    localparam logic [7:0] ADDR_CAPACITY  = 8'h0c;
    localparam logic [7:0] ADDR_GAUGE     = 8'h10;
    localparam logic [7:0] ADDR_CMD       = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;
    localparam logic [7:0] ADDR_TEMP      = 8'h1c;
    localparam logic [7:0] ADDR_RFLAG     = 8'h20;
    localparam logic [7:0] ADDR_RTAB      = 8'h40;
    // Operation configuration fields
    localparam int BIT_RESERVE_COMP_ENABLE_EN  = 7;
    localparam int BIT_LOWSEL     = 5;
    localparam int BIT_SLEEP_OK   = 4;
    localparam int BIT_REFILL     = 3;
    localparam int BIT_INS_PIN    = 2;
    localparam int BIT_POL        = 1;
    localparam int BIT_HOST_TEMP  = 0;
    localparam logic [7:0] OPCFG_RESET   = 8'h19;
    localparam logic [7:0] OPCFG_WMASK   = 8'hbf;
    // Low flag thresholds in mAh
    localparam logic [15:0] INIT_SET_DEF   = 16'h0096;
    localparam logic [15:0] INIT_CLR_DEF   = 16'h00af;
    localparam logic [15:0] FINAL_SET_DEF  = 16'h004b;
    localparam logic [15:0] FINAL_CLR_DEF  = 16'h0064;
    localparam logic [7:0]  STEP_DEF       = 8'h01;
    // Resistance table validity codes
    localparam logic [7:0] RFLAG_PAST      = 8'h00;
    localparam logic [7:0] RFLAG_DEFAULT   = 8'hff;
    localparam logic [7:0] RFLAG_IN_USE    = 8'h55;
    localparam int         RTAB_COUNT      = 2;
    localparam int         RTAB_POINTS     = 15;
    localparam logic [15:0] RTAB_DEF_VAL   = 16'h0066;
    // Command codes
    localparam logic [7:0] CMD_INSERT      = 8'h0c;
    localparam logic [7:0] CMD_REMOVE      = 8'h0d;
    localparam logic [7:0] CMD_FACTORY     = 8'h15;
    // Threshold divisors scaled by ten
    localparam logic [15:0] DIV_CHG_X10   = 16'h0085;
    localparam logic [15:0] DIV_DSG_X10   = 16'h00a7;
    localparam logic [15:0] DIV_QUIT_X10  = 16'h00fa;
    // Pulse timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int PULSE_US     = 1000;
    localparam int PULSE_CYC    = CLK_HZ / 1_000_000 * PULSE_US;
    // Battery states
    typedef enum logic [1:0] {
        GAC_RELAX = 2'b00,
        GAC_CHG   = 2'b01,
        GAC_DSG   = 2'b10
    } gac_bstate_t;
endpackage : gac_pkg

// file: gac_pulse.sv
// One-shot pulse generator for the alert output
`timescale 1ns/1ps
module gac_pulse
    import gac_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic reset,     // Async reset, active high
    input  wire logic trigger,   // Any pulse cause
    output logic      active     // High during pulse
);
    localparam int CW = $clog2(PULSE_CYCLES + 1);
    logic [CW-1:0] cnt_r;
    wire           busy = (cnt_r != '0);

    // Retriggers inside a running pulse merge into it
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cnt_r <= '0;
        end else if (busy) begin
            cnt_r <= cnt_r - 1'b1;
        end else if (trigger) begin
            cnt_r <= CW'(PULSE_CYCLES);
        end
    end
    assign active = busy;
endmodule : gac_pulse

// file: gac_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module gac_pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk_sys,   // System clock
    input  wire logic reset,     // Async reset, active high
    input  wire logic pin_in,    // Asynchronous pin
    output logic      level      // Filtered level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;

    // Stage chain, level moves when stages two and three agree
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            s1_r  <= RESET_VAL;
            s2_r  <= RESET_VAL;
            s3_r  <= RESET_VAL;
            lvl_r <= RESET_VAL;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                lvl_r <= s3_r;
            end
        end
    end
    assign level = lvl_r;
endmodule : gac_pin_sync

// file: gac_top.sv
// Alert output, operation configuration and resistance tables of the gauge
`timescale 1ns/1ps
module gac_top
    import gac_pkg::*;
#(
    parameter int PULSE_CYCLES = PULSE_CYC
) (
    input  wire logic        clk_sys,          // System clock 100 MHz
    input  wire logic        reset,            // Async reset, active high
    input  wire logic        wb_cyc_i,         // Wishbone cycle
    input  wire logic        wb_stb_i,         // Wishbone strobe
    input  wire logic        wb_we_i,          // Wishbone write enable
    input  wire logic [7:0]  wb_adr_i,         // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,         // Wishbone byte selects
    input  wire logic [31:0] wb_dat_i,         // Wishbone write data
    output logic [31:0]      wb_dat_o,         // Wishbone read data
    output logic             wb_ack_o,         // Wishbone acknowledge
    input  wire logic        insertion_input,  // Insertion pin, low = present
    input  wire logic [15:0] charge_left_mah,  // Remaining capacity from gauge
    input  wire logic [15:0] full_capacity_mah,// Full capacity from gauge
    input  wire logic [7:0]  charge_percent,   // State of charge 0..100
    input  wire logic signed [15:0] avg_current_ma, // Average current
    input  wire logic [15:0] design_capacity,  // Rated capacity mAh
    input  wire logic        charge_term,      // Valid termination pulse
    input  wire logic        sleep_cond,       // Sleep conditions met
    input  wire logic [15:0] sensor_temp,      // Internal temperature sensor
    output logic             alert_output,     // Alert pin level
    output logic             reserve_comp,     // Reserve compensation on
    output logic             sleep_allowed,    // Sleep entry allowed
    output logic             refill_load,      // Load remaining from full
    output logic [15:0]      refill_value,     // Value to load
    output logic [15:0]      temp_value,       // Temperature in use
    output logic             battery_present   // Battery detected
);
    // Register state
    logic [7:0]  opcfg_r;
    logic [15:0] init_set_r, init_clr_r, final_set_r, final_clr_r;
    logic [7:0]  step_r;
    logic [15:0] host_temp_r;
    // Both tables flat, table 0 first
    logic [7:0]  rflag_r [RTAB_COUNT];
    logic [15:0] rtab_r  [RTAB_COUNT*RTAB_POINTS];
    logic        init_low_r, final_low_r;
    logic        present_r;
    logic        ack_r;
    logic [31:0] rdat_r;
    gac_bstate_t bstate_r, bstate_nxt;
    logic [7:0]  last_pct_r;
    logic        pin_prev_r;
    logic        refill_r;
    logic [15:0] refill_val_r;
    logic        pulse_trig_r;

    // Byte-lane merge for writes
    // Lanes with select low keep the old byte
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : lane_merge

    // Capacity divided by a tenths divisor, in mA
    // Tenths keep the fractional ratios exact
    function automatic logic [15:0] cap_div(input logic [15:0] cap, input logic [15:0] div_x10);
        logic [19:0] num;
        num = {4'h0, cap} * 20'd10;
        return 16'(num / {4'h0, div_x10});
    endfunction : cap_div

    // Count of step levels strictly above a percentage
    // Levels are 100% less whole steps; 0 from 100% up
    // A zero step divides by zero, so users gate it
    function automatic logic [7:0] step_band(input logic [7:0] pct, input logic [7:0] step);
        logic [7:0] down;
        down = (pct >= 8'h64) ? 8'h00 : 8'(8'h64 - pct);
        return 8'(({1'b0, down} + {1'b0, step} - 9'h001) / {1'b0, step});
    endfunction : step_band

    // Bus decode
    // Ack is registered and masks the request,
    // so each access gets exactly one ack
    wire        bus_req   = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        bus_wr    = bus_req & wb_we_i;
    wire        rtab_hit  = (wb_adr_i >= ADDR_RTAB) &&
                            (wb_adr_i < 8'(ADDR_RTAB + 8'(RTAB_COUNT*RTAB_POINTS*4)));
    wire [4:0]  rtab_idx  = 5'((wb_adr_i - ADDR_RTAB) >> 2);
    wire        cmd_wr    = bus_wr && (wb_adr_i == ADDR_CMD) && wb_sel_i[0];
    wire        cmd_fact  = cmd_wr && (wb_dat_i[7:0] == CMD_FACTORY);
    wire        cmd_ins   = cmd_wr && (wb_dat_i[7:0] == CMD_INSERT);
    wire        cmd_rem   = cmd_wr && (wb_dat_i[7:0] == CMD_REMOVE);
    wire [31:0] wmerge_a  = lane_merge({init_clr_r, init_set_r}, wb_dat_i, wb_sel_i);
    wire [31:0] wmerge_b  = lane_merge({final_clr_r, final_set_r}, wb_dat_i, wb_sel_i);

    // Insertion pin, synchronised
    // Resets to the released level: no false removal
    logic pin_level;
    gac_pin_sync #(.RESET_VAL(1'b1)) u_pin (
        .clk_sys (clk_sys),
        .reset   (reset),
        .pin_in  (insertion_input),
        .level   (pin_level)
    );

    // Battery state thresholds
    // Between relax and active thresholds the state holds,
    // so a current near a threshold cannot chatter
    // divisor-based thresholds
    wire [15:0] thr_chg  = cap_div(design_capacity, DIV_CHG_X10);
    wire [15:0] thr_dsg  = cap_div(design_capacity, DIV_DSG_X10);
    wire [15:0] thr_quit = cap_div(design_capacity, DIV_QUIT_X10);
    wire signed [16:0] cur_s    = {avg_current_ma[15], avg_current_ma};
    wire               is_chg   = cur_s >  $signed({1'b0, thr_chg});
    wire               is_dsg   = cur_s < -$signed({1'b0, thr_dsg});
    wire               is_quiet = (cur_s < $signed({1'b0, thr_quit})) &&
                                  (cur_s > -$signed({1'b0, thr_quit}));

    // state classification with hold between thresholds
    // Charge and discharge tests never both hold
    always_comb begin
        bstate_nxt = bstate_r;
        case (bstate_r)
            GAC_RELAX: begin
                if (is_chg) bstate_nxt = GAC_CHG;
                else if (is_dsg) bstate_nxt = GAC_DSG;
            end
            GAC_CHG, GAC_DSG: begin
                if (is_quiet) bstate_nxt = GAC_RELAX;
                else if (is_chg) bstate_nxt = GAC_CHG;
                else if (is_dsg) bstate_nxt = GAC_DSG;
            end
            default: bstate_nxt = GAC_RELAX;
        endcase
    end

    // Pulse causes
    // Causes compare with last cycle's copy, so a
    // steady input raises no second pulse
    wire        step_on     = (step_r != 8'h00);
    wire [7:0]  band_now    = step_band(charge_percent, step_r);
    wire [7:0]  band_last   = step_band(last_pct_r, step_r);
    // rising through a step level or reaching 100%
    // Reaching 100% from below counts while in the charge state with a non-zero step
    wire        chg_cross   = step_on && (bstate_r == GAC_CHG) && (charge_percent > last_pct_r) &&
                              ((band_now < band_last) || (charge_percent >= 8'h64 && last_pct_r < 8'h64));
    // falling below a step level or to 0%
    // More levels above the new value means one was passed
    wire        dsg_cross   = step_on && (bstate_r == GAC_DSG) && (charge_percent < last_pct_r) &&
                              ((band_now > band_last) || (charge_percent == 8'h00));
    wire        state_chg   = step_on && (bstate_nxt != bstate_r);
    // removal edge on insertion pin
    // Pin is high with no battery: removal rises
    wire        removal     = opcfg_r[BIT_INS_PIN] && pin_level && !pin_prev_r;
    wire        pulse_cause = chg_cross | dsg_cross | state_chg | removal;

    // Bus and configuration registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            opcfg_r     <= OPCFG_RESET;
            init_set_r  <= INIT_SET_DEF;
            init_clr_r  <= INIT_CLR_DEF;
            final_set_r <= FINAL_SET_DEF;
            final_clr_r <= FINAL_CLR_DEF;
            step_r      <= STEP_DEF;
            host_temp_r <= 16'h00fa;
            ack_r       <= 1'b0;
        end else begin
            ack_r <= bus_req;
            if (bus_wr) begin
                case (wb_adr_i)
                    // Reserved bit masked, reads back zero
                    ADDR_OPCFG: if (wb_sel_i[0]) opcfg_r <= wb_dat_i[7:0] & OPCFG_WMASK;
                    // A pair shares a word; lanes reach one half
                    ADDR_THRESH_A: begin
                        init_set_r <= wmerge_a[15:0];
                        init_clr_r <= wmerge_a[31:16];
                    end
                    ADDR_THRESH_B: begin
                        final_set_r <= wmerge_b[15:0];
                        final_clr_r <= wmerge_b[31:16];
                    end
                    ADDR_GAUGE: if (wb_sel_i[0]) step_r <= wb_dat_i[7:0];
                    // host temperature only accepted when enabled
                    ADDR_TEMP: if (opcfg_r[BIT_HOST_TEMP]) begin
                        host_temp_r <= 16'(lane_merge({16'h0000, host_temp_r}, wb_dat_i, wb_sel_i));
                    end
                    default: ;
                endcase
            end
        end
    end

    // Resistance tables and validity bytes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rflag_r[0] <= RFLAG_IN_USE;
            rflag_r[1] <= RFLAG_DEFAULT;
            for (int i = 0; i < RTAB_COUNT*RTAB_POINTS; i++) rtab_r[i] <= RTAB_DEF_VAL;
        end else if (cmd_fact) begin
            // factory restore of both tables
            // Restore wins over a same-cycle table write
            rflag_r[0] <= RFLAG_IN_USE;
            rflag_r[1] <= RFLAG_DEFAULT;
            for (int i = 0; i < RTAB_COUNT*RTAB_POINTS; i++) rtab_r[i] <= RTAB_DEF_VAL;
        end else if (bus_wr && rtab_hit) begin
            // indexed write of one resistance value
            rtab_r[rtab_idx] <= 16'(lane_merge({16'h0000, rtab_r[rtab_idx]}, wb_dat_i, wb_sel_i));
            // an updated table leaves the default code
            if (rflag_r[rtab_idx >= 5'(RTAB_POINTS)] == RFLAG_DEFAULT) begin
                rflag_r[rtab_idx >= 5'(RTAB_POINTS)] <= RFLAG_PAST;
            end
        end else if (bus_wr && wb_adr_i == ADDR_RFLAG) begin
            // software selects the table in use
            if (wb_sel_i[0]) rflag_r[0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) rflag_r[1] <= wb_dat_i[15:8];
        end
    end

    // Read data mux
    // Captured when the request is taken, then held
    // until the next request
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rdat_r <= 32'h0000_0000;
        end else if (bus_req) begin
            if (rtab_hit) begin
                rdat_r <= {16'h0000, rtab_r[rtab_idx]};
            end else begin
                case (wb_adr_i)
                    ADDR_OPCFG:    rdat_r <= {24'h000000, opcfg_r};
                    ADDR_THRESH_A: rdat_r <= {init_clr_r, init_set_r};
                    ADDR_THRESH_B: rdat_r <= {final_clr_r, final_set_r};
                    ADDR_CAPACITY: rdat_r <= {full_capacity_mah, charge_left_mah};
                    ADDR_GAUGE:    rdat_r <= {8'h00, charge_percent, 8'h00, step_r};
                    ADDR_STATUS:   rdat_r <= {24'h000000, 2'b00, bstate_r, present_r,
                                              pin_level, final_low_r, init_low_r};
                    ADDR_TEMP:     rdat_r <= {16'h0000, temp_value};
                    // validity bytes, meaningful in normal operation
                    ADDR_RFLAG:    rdat_r <= {16'h0000, rflag_r[1], rflag_r[0]};
                    default:       rdat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Low flags, insertion and gauge-side state
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            init_low_r   <= 1'b0;
            final_low_r  <= 1'b0;
            present_r    <= 1'b0;
            bstate_r     <= GAC_RELAX;
            last_pct_r   <= 8'h00;
            pin_prev_r   <= 1'b1;
            refill_r     <= 1'b0;
            refill_val_r <= 16'h0000;
            pulse_trig_r <= 1'b0;
        end else begin
            // Separate set and clear levels give hysteresis;
            // set is tested first and wins
            // set below threshold, clear above clear threshold
            if (charge_left_mah < init_set_r) init_low_r <= 1'b1;
            else if (charge_left_mah > init_clr_r) init_low_r <= 1'b0;
            if (charge_left_mah < final_set_r) final_low_r <= 1'b1;
            else if (final_low_r && charge_left_mah > final_clr_r) final_low_r <= 1'b0;
            // insertion from pin or host command
            // In pin mode the host commands are ignored
            pin_prev_r <= pin_level;
            if (opcfg_r[BIT_INS_PIN]) present_r <= ~pin_level;
            else if (cmd_ins) present_r <= 1'b1;
            else if (cmd_rem) present_r <= 1'b0;
            bstate_r   <= bstate_nxt;
            last_pct_r <= charge_percent;
            // reload remaining capacity on termination
            // Value is registered beside the strobe
            refill_r     <= charge_term & opcfg_r[BIT_REFILL];
            refill_val_r <= full_capacity_mah;
            // Causes are dropped in level mode, so a later
            // switch to pulse mode replays nothing
            pulse_trig_r <= pulse_cause & ~opcfg_r[BIT_LOWSEL];
        end
    end

    // Pulse timer
    logic pulse_active;
    // one 1 ms pulse, merged triggers
    // Default width is 1 ms at 100 MHz
    gac_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_pulse (
        .clk_sys (clk_sys),
        .reset   (reset),
        .trigger (pulse_trig_r),
        .active  (pulse_active)
    );

    // Output selection
    // function select, level mirrors initial low flag
    wire alert_act = opcfg_r[BIT_LOWSEL] ? init_low_r : pulse_active;
    // Toggling polarity flips the pin at once;
    // change it while the alert is idle
    // polarity, inactive level otherwise
    assign alert_output    = opcfg_r[BIT_POL] ? alert_act : ~alert_act;
    assign reserve_comp    = opcfg_r[BIT_RESERVE_COMP_ENABLE_EN];
    assign sleep_allowed   = opcfg_r[BIT_SLEEP_OK] & sleep_cond;
    assign refill_load     = refill_r;
    assign refill_value    = refill_val_r;
    assign temp_value      = opcfg_r[BIT_HOST_TEMP] ? host_temp_r : sensor_temp;
    assign battery_present = present_r;
    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = rdat_r;
endmodule : gac_top

// file: gac_top_sva.sv
// Port checker for the gauge alert configuration block
`timescale 1ns/1ps
module gac_top_sva
    import gac_pkg::*;
(
    input wire logic        clk_sys,       // Clock
    input wire logic        reset,         // Reset
    input wire logic        wb_cyc_i,      // Cycle
    input wire logic        wb_stb_i,      // Strobe
    input wire logic        wb_we_i,       // Write
    input wire logic [7:0]  wb_adr_i,      // Address
    input wire logic [31:0] wb_dat_o,      // Read data
    input wire logic        wb_ack_o,      // Ack
    input wire logic        charge_term,   // Termination
    input wire logic        sleep_cond,    // Sleep ok
    input wire logic        reserve_comp,  // Compensation
    input wire logic        sleep_allowed, // Sleep gate
    input wire logic        refill_load    // Refill pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    unmapped_read_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i == 8'h24
        |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o)) else $error("read data moved");
    sleep_gate_a: assert property (sleep_allowed |-> sleep_cond) else $error("sleep without cause");
    refill_cause_a: assert property (refill_load |-> $past(charge_term)) else $error("refill no cause");
    config_hold_a: assert property (!(wb_cyc_i && wb_we_i && wb_adr_i == ADDR_OPCFG)
        |=> $stable(reserve_comp)) else $error("compensation moved");
endmodule : gac_top_sva

// file: gac_host.sv
// Host model issuing classic Wishbone single cycles
`timescale 1ns/1ps
module gac_host (
    input  wire logic        clk_sys,  // Clock
    input  wire logic        wb_ack_o, // Ack
    input  wire logic [31:0] wb_dat_o, // Read data
    output logic             wb_cyc_i, // Cycle
    output logic             wb_stb_i, // Strobe
    output logic             wb_we_i,  // Write
    output logic [7:0]       wb_adr_i, // Address
    output logic [3:0]       wb_sel_i, // Selects
    output logic [31:0]      wb_dat_i  // Write data
);
    // Idle bus at time zero
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask : xfer
endmodule : gac_host

// file: gac_top_tb.sv
// Self-checking bench for the gauge alert configuration block
`timescale 1ns/1ps
module gac_top_tb;
    import gac_pkg::*;
    logic               clk_sys = 1'b0;
    logic               reset = 1'b1;
    logic               cyc, stb, we, ack, alert, rcomp, sleep_a, rload, present;
    logic [7:0]         adr;
    logic [3:0]         sel;
    logic [31:0]        dw, dr;
    logic [15:0]        rval, temp;
    logic               ins = 1'b1;
    logic               term_p = 1'b0;
    logic               scond = 1'b1;
    logic [15:0]        left = 16'd1000;
    logic [7:0]         pct = 8'd45;
    logic signed [15:0] cur = 16'sd0;
    int                 fails = 0;
    int                 compares = 0;
    int                 cycles = 0;
    logic [7:0]         da[6] = '{ADDR_OPCFG, ADDR_THRESH_A, ADDR_THRESH_B, ADDR_RFLAG, ADDR_RTAB, ADDR_TEMP};
    logic [31:0]        dv[6] = '{32'h19, 32'h00af0096, 32'h0064004b, 32'hff55, 32'h66, 32'hfa};
    int                 lv[8] = '{150, 149, 170, 176, 74, 90, 101, 176};
    logic [1:0]         ls[8] = '{0, 1, 1, 0, 3, 3, 1, 0};
    int                 pc[6] = '{500, 500, -500, -500, -500, 20};
    int                 pp[6] = '{45, 50, 50, 49, 48, 48};
    int                 pn[6] = '{20, 20, 20, 20, 0, 20};
    logic [1:0]         ps[6] = '{1, 1, 2, 2, 2, 0};
    always #5 clk_sys = ~clk_sys;
    gac_host h (.clk_sys(clk_sys), .wb_ack_o(ack), .wb_dat_o(dr), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw));
    gac_top #(.PULSE_CYCLES(20)) i_dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
        .insertion_input(ins), .charge_left_mah(left), .full_capacity_mah(16'd1200), .charge_percent(pct),
        .avg_current_ma(cur), .design_capacity(16'd1330), .charge_term(term_p), .sleep_cond(scond),
        .sensor_temp(16'h0123), .alert_output(alert), .reserve_comp(rcomp), .sleep_allowed(sleep_a),
        .refill_load(rload), .refill_value(rval), .temp_value(temp), .battery_present(present));
    task automatic test_done();
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        h.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask : rdm
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        h.xfer(1'b1, a, d, q);
    endtask : wr
    // Waits for an active-low pulse and checks its length
    task automatic pulse(input int n);
        int w;
        int c;
        w = 0;
        c = 0;
        while (alert !== 1'b0 && w < 60) begin
            @(posedge clk_sys);
            w++;
        end
        while (alert === 1'b0 && c < 200) begin
            @(posedge clk_sys);
            c++;
        end
        chk(32'(c), 32'(n));
    endtask : pulse
    task automatic term(input logic [31:0] e);
        @(posedge clk_sys);
        term_p <= 1'b1;
        @(posedge clk_sys);
        term_p <= 1'b0;
        #1;
        chk({15'h0, rload, rload ? rval : 16'h0}, e);
    endtask : term
    // Cuts a hung run short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 6; i++) rdm(da[i], 32'hffffffff, dv[i]);
        chk({rcomp, sleep_a, temp}, {2'b01, 16'h00fa});
        scond <= 1'b0;
        rdm(ADDR_CAPACITY, 32'hffffffff, {16'd1200, 16'd1000});
        chk({31'h0, sleep_a}, 32'h0);
        scond <= 1'b1;
        wr(ADDR_TEMP, 32'h0155);
        rdm(ADDR_TEMP, 32'hffff, 32'h0155);
        wr(ADDR_OPCFG, 32'hff);
        rdm(ADDR_OPCFG, 32'hff, 32'hbf);
        chk({31'h0, rcomp}, 32'h1);
        wr(ADDR_OPCFG, 32'h08);
        chk({rcomp, sleep_a, temp}, {2'b00, 16'h0123});
        term({15'h1, 16'd1200});
        wr(ADDR_OPCFG, 32'h00);
        term(32'h0);
        wr(ADDR_TEMP, 32'h0077);
        wr(ADDR_OPCFG, 32'h01);
        rdm(ADDR_TEMP, 32'hffff, 32'h0155);
        wr(8'h24, 32'hffffffff);
        rdm(8'h24, 32'hffffffff, 32'h0);
        wr(ADDR_OPCFG, 32'h20);
        for (int i = 0; i < 8; i++) begin
            left <= 16'(lv[i]);
            rdm(ADDR_STATUS, 32'h3, 32'(ls[i]));
            chk({31'h0, alert}, {31'h0, ~ls[i][0]});
        end
        wr(ADDR_OPCFG, 32'h22);
        left <= 16'd149;
        rdm(ADDR_STATUS, 32'h1, 32'h1);
        chk({31'h0, alert}, 32'h1);
        left <= 16'd1000;
        wr(ADDR_OPCFG, 32'h00);
        wr(ADDR_GAUGE, 32'h0a);
        rdm(ADDR_GAUGE, 32'hffffffff, 32'h002d000a);
        for (int i = 0; i < 6; i++) begin
            cur <= 16'(pc[i]);
            pct <= 8'(pp[i]);
            pulse(pn[i]);
            rdm(ADDR_STATUS, 32'h30, {26'h0, ps[i], 4'h0});
        end
        wr(ADDR_GAUGE, 32'h00);
        cur <= 16'sd500;
        pulse(0);
        wr(ADDR_OPCFG, 32'h04);
        ins <= 1'b0;
        pulse(0);
        chk({31'h0, present}, 32'h1);
        ins <= 1'b1;
        pulse(20);
        chk({31'h0, present}, 32'h0);
        wr(ADDR_OPCFG, 32'h00);
        wr(ADDR_CMD, {24'h0, CMD_INSERT});
        rdm(ADDR_STATUS, 32'h8, 32'h8);
        wr(ADDR_CMD, {24'h0, CMD_REMOVE});
        rdm(ADDR_STATUS, 32'h8, 32'h0);
        wr(ADDR_RTAB, 32'h1234);
        wr(8'h7c, 32'h1234);
        rdm(ADDR_RFLAG, 32'hffff, 32'h0055);
        rdm(8'h7c, 32'hffff, 32'h1234);
        wr(ADDR_CMD, {24'h0, CMD_FACTORY});
        rdm(ADDR_RTAB, 32'hffff, 32'h66);
        rdm(8'h7c, 32'hffff, 32'h66);
        test_done();
    end
endmodule : gac_top_tb
bind gac_top gac_top_sva i_sva (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .charge_term(charge_term),
    .sleep_cond(sleep_cond), .reserve_comp(reserve_comp), .sleep_allowed(sleep_allowed), .refill_load(refill_load));
